// >>> hw/bctl_pkg.sv
// package: constants, encodings and state type of the bus-control block
package bctl_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LVL_W = 3;

  // ------------------------------------------------------------------
  // synchronised input vector, bit positions
  // ------------------------------------------------------------------
  localparam int unsigned IN_W = 12;
  localparam int unsigned IN_LVL = 0;   // three bits, 2..0
  localparam int unsigned IN_ACK_LO = 3;
  localparam int unsigned IN_ACK_HI = 4;
  localparam int unsigned IN_AUTO_VECTOR_REQUEST_N = 5;
  localparam int unsigned IN_BREQ = 6;
  localparam int unsigned IN_GACK = 7;
  localparam int unsigned IN_BUS_ERROR_N = 8;
  localparam int unsigned IN_HALT = 9;
  localparam int unsigned IN_RST = 10;
  localparam int unsigned IN_CACHE_DISABLE_N = 11;

  // ------------------------------------------------------------------
  // port width answered by the two acknowledge inputs
  // ------------------------------------------------------------------
  localparam logic [1:0] PORT_8 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;

  // ------------------------------------------------------------------
  // reset values and timing counts
  // ------------------------------------------------------------------
  localparam logic NEG_N = 1'b1;        // negated level of active-low pins
  localparam logic RW_READ = 1'b1;
  localparam int unsigned RST_DRIVE_CYC = 16;
  localparam int unsigned RST_GUARD_CYC = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WAIT,
    ST_SEND,
    ST_RETRY
  } bctl_state_t;
endpackage

// >>> hw/bctl_irq_if.sv
// interface: interrupt level, mask and pending between core and comparator
`timescale 1ns/100ps
interface bctl_irq_if;
  logic [2:0] level_n;
  logic [2:0] mask;
  logic pending;
  modport core (output level_n, output mask, input pending);
  modport irq (input level_n, input mask, output pending);
endinterface

// >>> hw/bctl_sync.sv
// module: two flip-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module bctl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // ------------------------------------------------------------------
  // first stage feeds only the second
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      meta_r <= INIT;
      q_o <= INIT;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // bctl_sync

// >>> hw/bctl_irq.sv
// module: interrupt level decode and compare against the priority mask
`timescale 1ns/100ps
module bctl_irq
  import bctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  bctl_irq_if.irq p
);
  logic [LVL_W-1:0] level;

  // ------------------------------------------------------------------
  // pins are active low, top line most significant
  // ------------------------------------------------------------------
  assign level = ~p.level_n;

  // pending once the request exceeds the mask
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      p.pending <= 1'b0;
    end else begin
      p.pending <= (level > p.mask);
    end
  end
endmodule // bctl_irq

// >>> hw/bctl_top.sv
// module: external bus-control, arbitration, exception and cache-disable signalling
// Notes on behaviour
// - locked rmw indicator stays asserted across all cycles of a locked sequence.
// - address strobe asserted only with address, function code, size, direction valid.
// - read cycle data strobe tells the addressed device to drive data.
// - write cycle data strobe asserted only after write data is driven.
// - data strobe stays negated through two-clock synchronous writes.
// - acknowledge inputs honoured for asynchronous cycles only.
// - interrupt level pins are active low, top line most significant.
// - pending output asserted when requested level exceeds the priority mask.
// - autovector during interrupt acknowledge with halt negated makes the vector internal.
// - bus grant means the bus is released once the current cycle ends.
// - reset and halt are open-drain: pull low or release, never drive high.
// - reset from outside resets internal state too.
// - reset instruction drives the reset line without resetting internal state.
// - halt from outside alone suspends bus activity until released.
// - bus error with halt retries the current cycle.
// - bus error alone ends the current cycle as a bus error.
// - after a double bus fault the device itself pulls halt.
// - cache disable input disables the cache statically without flushing it.
// - direction output high for read, low for write.
`timescale 1ns/100ps
module bctl_top
  import bctl_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_DRIVE_CYC
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_sync_i,
  input wire logic req_lock_i,
  input wire logic req_iack_i,
  input wire logic [2:0] req_fc_i,
  input wire logic [1:0] req_size_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [LVL_W-1:0] irq_mask_i,
  input wire logic reset_instr_i,
  input wire logic double_fault_i,
  output logic req_done_o,
  output logic req_bus_error_n_o,
  output logic req_autovec_o,
  output logic [1:0] req_port_o,
  output logic [DATA_W-1:0] req_rdata_o,
  output logic core_reset_o,
  output logic cache_enable_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [2:0] function_code_o,
  output logic [1:0] transfer_size_o,
  output logic rw_o,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic locked_rmw_cycle_n_o,
  output logic bus_oe_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic transfer_ack_size_hi_n_i,
  input wire logic transfer_ack_size_lo_n_i,
  input wire logic [LVL_W-1:0] interrupt_level_n_i,
  output logic interrupt_pending_out_n_o,
  input wire logic auto_vector_request_n_i,
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o,
  input wire logic grant_acknowledge_n_i,
  input wire logic bus_error_n_i,
  input wire logic reset_n_i,
  output logic reset_n_o,
  output logic reset_oe_o,
  input wire logic halt_n_i,
  output logic halt_n_o,
  output logic halt_oe_o,
  input wire logic cache_disable_n_i
);
  // ------------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------------
  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sin;
  logic ack_hi, ack_lo, auto_vector_request_n, breq, gack, bus_error_n, halt, xrst;

  assign raw_in = {cache_disable_n_i, reset_n_i, halt_n_i, bus_error_n_i, grant_acknowledge_n_i,
                   bus_request_n_i, auto_vector_request_n_i, transfer_ack_size_hi_n_i,
                   transfer_ack_size_lo_n_i, interrupt_level_n_i};

  bctl_sync #(.W(IN_W), .INIT('1)) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i(raw_in),
    .q_o(sin)
  );

  // active-high views of the synchronised pins
  assign ack_hi = !sin[IN_ACK_HI];
  assign ack_lo = !sin[IN_ACK_LO];
  assign auto_vector_request_n = !sin[IN_AUTO_VECTOR_REQUEST_N];
  assign breq = !sin[IN_BREQ];
  assign gack = !sin[IN_GACK];
  assign bus_error_n = !sin[IN_BUS_ERROR_N];
  assign halt = !sin[IN_HALT];
  assign xrst = !sin[IN_RST];

  // ------------------------------------------------------------------
  // internal reset: own pin or outside reset line
  // ------------------------------------------------------------------
  logic rst_any;
  logic rst_self_r;
  logic [1:0] rst_guard_r;
  localparam int unsigned CNT_W = $clog2(RST_CYC + 1);
  logic [CNT_W-1:0] rst_cnt_r;

  // own drive seen back through the synchroniser must not reset us
  assign rst_any = !nrst_i || (xrst && !rst_self_r && (rst_guard_r == 2'h0));

  // reset instruction: pull the line for a fixed count, external devices only
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_self_r <= 1'b0;
      rst_cnt_r <= '0;
    end else if (reset_instr_i && !rst_self_r) begin
      rst_self_r <= 1'b1;
      rst_cnt_r <= CNT_W'(RST_CYC - 1);
    end else if (rst_self_r) begin
      if (rst_cnt_r == '0) begin
        rst_self_r <= 1'b0;
      end else begin
        rst_cnt_r <= rst_cnt_r - 1'b1;
      end
    end
  end

  // masks the synchroniser tail after release
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rst_guard_r <= 2'h0;
    end else if (rst_self_r) begin
      rst_guard_r <= 2'(RST_GUARD_CYC);
    end else if (rst_guard_r != 2'h0) begin
      rst_guard_r <= rst_guard_r - 2'h1;
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge core_clk_i) begin
    reset_n_o <= 1'b0;
    halt_n_o <= 1'b0;
    if (!nrst_i) begin
      reset_oe_o <= 1'b0;
      halt_oe_o <= 1'b0;
    end else begin
      reset_oe_o <= rst_self_r;
      halt_oe_o <= double_fault_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    core_reset_o <= rst_any;
  end

  // ------------------------------------------------------------------
  // interrupt level and pending
  // ------------------------------------------------------------------
  bctl_irq_if irq_if ();
  assign irq_if.level_n = sin[IN_LVL +: LVL_W];
  assign irq_if.mask = irq_mask_i;

  bctl_irq u_irq (
    .core_clk_i(core_clk_i),
    .rst_i(rst_any),
    .p(irq_if.irq)
  );

  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      interrupt_pending_out_n_o <= NEG_N;
    end else begin
      interrupt_pending_out_n_o <= !irq_if.pending;
    end
  end

  // ------------------------------------------------------------------
  // cache disable: a level only, nothing is flushed
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      cache_enable_o <= 1'b0;
    end else begin
      cache_enable_o <= sin[IN_CACHE_DISABLE_N];
    end
  end

  // ------------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------------
  bctl_state_t state_r, state_nxt;
  logic cyc_write_r, cyc_sync_r, cyc_iack_r, lock_r;
  logic start, acked, end_ok, end_bus_error_n, end_retry, end_auto_vector_request_n;

  // halt, grant or a fault hold off any new cycle
  assign start = req_valid_i && !halt && !bus_grant_n_o ? 1'b0 :
                 req_valid_i && !halt && !gack && !double_fault_i;
  assign acked = (ack_hi || ack_lo) && !cyc_sync_r;
  assign end_retry = bus_error_n && halt;
  assign end_bus_error_n = bus_error_n && !halt;
  assign end_auto_vector_request_n = cyc_iack_r && auto_vector_request_n && !bus_error_n;
  assign end_ok = (state_r == ST_SEND) || (state_r == ST_WAIT && (acked || end_auto_vector_request_n));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_nxt = cyc_sync_r ? ST_SEND : ST_WAIT;
      end
      ST_WAIT, ST_SEND: begin
        if (end_retry) begin
          state_nxt = ST_RETRY;
        end else if (end_bus_error_n || end_ok) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RETRY: begin
        if (!halt) begin
          state_nxt = ST_ADDR;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle attributes latched at start and held for retries
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      cyc_write_r <= 1'b0;
      cyc_sync_r <= 1'b0;
      cyc_iack_r <= 1'b0;
      addr_o <= '0;
      function_code_o <= 3'h0;
      transfer_size_o <= 2'h0;
      data_o <= '0;
      rw_o <= RW_READ;
    end else if (state_r == ST_IDLE && start) begin
      cyc_write_r <= req_write_i;
      cyc_sync_r <= req_sync_i;
      cyc_iack_r <= req_iack_i;
      addr_o <= req_addr_i;
      function_code_o <= req_fc_i;
      transfer_size_o <= req_size_i;
      data_o <= req_wdata_i;
      rw_o <= !req_write_i;
    end
  end

  // strobes follow the next state so outputs come from flops
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      address_strobe_n_o <= NEG_N;
      data_strobe_n_o <= NEG_N;
      data_oe_o <= 1'b0;
    end else begin
      address_strobe_n_o <= !(state_nxt inside {ST_ADDR, ST_WAIT, ST_SEND});
      // write data is out one cycle ahead of the strobe
      data_strobe_n_o <= !(state_nxt == ST_WAIT ||
                           (state_nxt == ST_SEND && !cyc_write_r));
      // latched direction is still the old one on the starting edge
      data_oe_o <= (state_r == ST_IDLE && start) ? req_write_i :
                   cyc_write_r && (state_nxt inside {ST_ADDR, ST_WAIT, ST_SEND});
    end
  end

  // locked indicator spans gaps between cycles while the core keeps lock
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      lock_r <= 1'b0;
      locked_rmw_cycle_n_o <= NEG_N;
    end else begin
      if (state_r == ST_IDLE && start && req_lock_i) begin
        lock_r <= 1'b1;
        locked_rmw_cycle_n_o <= 1'b0;
      end else if (state_r == ST_IDLE && !req_lock_i) begin
        lock_r <= 1'b0;
        locked_rmw_cycle_n_o <= NEG_N;
      end
    end
  end

  // completion reported to the core: done, bus error and autovector as one-cycle pulses, port and read data held
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      req_done_o <= 1'b0;
      req_bus_error_n_o <= 1'b0;
      req_autovec_o <= 1'b0;
      req_port_o <= PORT_32;
      req_rdata_o <= '0;
    end else begin
      req_done_o <= (state_r inside {ST_WAIT, ST_SEND}) && end_ok && !bus_error_n;
      req_bus_error_n_o <= (state_r inside {ST_WAIT, ST_SEND}) && end_bus_error_n;
      req_autovec_o <= state_r == ST_WAIT && end_auto_vector_request_n && !halt;
      if (state_r == ST_WAIT && acked && !bus_error_n) begin
        // both low 32, high only 16, low only 8
        req_port_o <= (ack_hi && ack_lo) ? PORT_32 : (ack_hi ? PORT_16 : PORT_8);
      end
      if (end_ok && !bus_error_n && !cyc_write_r && !end_auto_vector_request_n) begin
        req_rdata_o <= data_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // arbitration: grant waits on a locked sequence
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      bus_grant_n_o <= NEG_N;
      bus_oe_o <= 1'b0;
    end else begin
      bus_grant_n_o <= !(breq && !gack && !lock_r);
      // release drivers once idle under grant or while another master holds
      bus_oe_o <= !(gack || (!bus_grant_n_o && state_nxt == ST_IDLE));
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_any);

  sequence s_sync_start;
    $fell(address_strobe_n_o) && cyc_sync_r;
  endsequence
  sequence s_two_clock;
    !address_strobe_n_o ##1 address_strobe_n_o;
  endsequence

  property p_rmw_nogap;
    (!locked_rmw_cycle_n_o && req_lock_i) |=> !locked_rmw_cycle_n_o;
  endproperty
  a_rmw_nogap: assert property (p_rmw_nogap) else $error("lock dropped mid sequence");

  property p_as_valid;
    (!address_strobe_n_o && $past(!address_strobe_n_o)) |->
      $stable(function_code_o) && $stable(transfer_size_o) && $stable(rw_o) && $stable(addr_o);
  endproperty
  a_as_valid: assert property (p_as_valid) else $error("attributes moved under strobe");

  property p_wr_data_first;
    (!data_strobe_n_o && !rw_o) |-> data_oe_o && $past(data_oe_o);
  endproperty
  a_wr_data_first: assert property (p_wr_data_first) else $error("write strobe before data");

  property p_sync_no_ds;
    (cyc_sync_r && cyc_write_r && !address_strobe_n_o) |-> data_strobe_n_o;
  endproperty
  a_sync_no_ds: assert property (p_sync_no_ds) else $error("strobe in sync write");

  property p_sync_len;
    s_sync_start |=> s_two_clock;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync cycle not two clocks");

  property p_pend;
    ($stable(interrupt_level_n_i) && $stable(irq_mask_i))[*5] ##0
      ((~interrupt_level_n_i) > irq_mask_i) |-> !interrupt_pending_out_n_o;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not raised");

  property p_auto_vector_request_n;
    (state_r == ST_WAIT && cyc_iack_r && auto_vector_request_n && !bus_error_n && !halt) |=> req_autovec_o && req_done_o;
  endproperty
  a_auto_vector_request_n: assert property (p_auto_vector_request_n) else $error("autovector not taken");

  property p_grant_hold;
    (!bus_grant_n_o && state_r == ST_IDLE) |=> address_strobe_n_o;
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("cycle started under grant");

  property p_retry;
    (state_r == ST_WAIT && bus_error_n && halt) |=> !req_bus_error_n_o && address_strobe_n_o && state_r == ST_RETRY;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not taken");

  property p_bus_error_n;
    (state_r inside {ST_WAIT, ST_SEND} && bus_error_n && !halt) |=> req_bus_error_n_o && !req_done_o;
  endproperty
  a_bus_error_n: assert property (p_bus_error_n) else $error("bus error not reported");

  property p_halt_stall;
    (halt && state_r == ST_IDLE) |=> address_strobe_n_o;
  endproperty
  a_halt_stall: assert property (p_halt_stall) else $error("cycle under halt");

  property p_dfault;
    double_fault_i |=> halt_oe_o && !halt_n_o;
  endproperty
  a_dfault: assert property (p_dfault) else $error("halt not pulled");

  property p_self_rst;
    reset_oe_o |-> !core_reset_o ##1 !core_reset_o;
  endproperty
  a_self_rst: assert property (p_self_rst) else $error("own reset hit core");

  property p_rw;
    (state_r == ST_ADDR) |-> rw_o == !cyc_write_r;
  endproperty
  a_rw: assert property (p_rw) else $error("direction wrong");
endmodule // bctl_top

// >>> tb/bctl_mem_model.sv
// partner model: asynchronous memory responder on the external bus pins
`timescale 1ns/100ps
module bctl_mem_model
  import bctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic as_n_i,
  input wire logic ds_n_i,
  input wire logic rw_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [3:0] dly_i,
  input wire logic [1:0] width_i,
  output logic [DATA_W-1:0] data_o,
  output logic ack_hi_n_o,
  output logic ack_lo_n_o
);
  // ------------------------------------------------------------------
  // response timing
  // ------------------------------------------------------------------
  logic [3:0] cnt_r = 4'h0;
  logic ack_r = 1'b1;
  logic [DATA_W-1:0] last_r = '0;
  // ack after dly_i strobed cycles
  always @(posedge core_clk_i) begin
    if (as_n_i) begin
      cnt_r <= 4'h0;
      ack_r <= 1'b1;
    end else if (!ds_n_i) begin
      if (cnt_r >= dly_i) ack_r <= 1'b0;
      else cnt_r <= cnt_r + 4'h1;
    end
  end
  // both low 32, high only 16, low only 8; dropped with the strobe so no stale ack survives
  assign ack_hi_n_o = ack_r | as_n_i | (width_i == PORT_8);
  assign ack_lo_n_o = ack_r | as_n_i | (width_i == PORT_16);
  // data only while strobed, else the inverse of the last value
  assign data_o = (!ds_n_i && rw_i) ? (addr_i ^ 32'hA5A5_0F0F) : ~last_r;
  always @(posedge core_clk_i) if (!ds_n_i && rw_i) last_r <= data_o;
endmodule // bctl_mem_model

// >>> tb/tb.sv
// testbench: scenario tasks for the bus-control block against a memory model
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; $display("wrong value %s %0h %0h", n, e, s); end end
`define WT(c, n) for (int k = 0; !(c); k++) begin if (k == (n)) begin fails++; results(); end @(negedge core_clk_i); end
module tb;
  import bctl_pkg::*;
  // ------------------------------------------------------------------
  // pins, open-drain lines and instances
  // ------------------------------------------------------------------
  localparam int unsigned RC = 4; // short reset drive keeps the run brief
  logic core_clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_sync_i = 1'b0;
  logic req_lock_i = 1'b0, req_iack_i = 1'b0, reset_instr_i = 1'b0, double_fault_i = 1'b0;
  logic [2:0] req_fc_i = 3'h0, irq_mask_i = 3'h0, interrupt_level_n_i = 3'h7;
  logic [1:0] req_size_i = 2'h0;
  logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0;
  logic auto_vector_request_n_i = 1'b1, bus_request_n_i = 1'b1, grant_acknowledge_n_i = 1'b1;
  logic bus_error_n_i = 1'b1, cache_disable_n_i = 1'b1, ext_rst_n = 1'b1, ext_halt_n = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [1:0] pw = PORT_32;
  logic req_done_o, req_bus_error_n_o, req_autovec_o, core_reset_o, cache_enable_o, rw_o, address_strobe_n_o;
  logic data_strobe_n_o, locked_rmw_cycle_n_o, bus_oe_o, data_oe_o, interrupt_pending_out_n_o, bus_grant_n_o;
  logic reset_n_o, reset_oe_o, halt_n_o, halt_oe_o, reset_n_i, halt_n_i;
  logic transfer_ack_size_hi_n_i, transfer_ack_size_lo_n_i;
  logic [1:0] req_port_o, transfer_size_o;
  logic [2:0] function_code_o;
  logic [31:0] req_rdata_o, addr_o, data_o, data_i;
  int fails = 0, checked = 0;
  // a line is low while any party pulls it
  assign reset_n_i = ext_rst_n & (reset_oe_o ? reset_n_o : 1'b1);
  assign halt_n_i = ext_halt_n & (halt_oe_o ? halt_n_o : 1'b1);
  always #4 core_clk_i = ~core_clk_i;
  bctl_top #(.RST_CYC(RC)) uut (.*);
  bctl_mem_model mem (.core_clk_i(core_clk_i), .as_n_i(address_strobe_n_o), .ds_n_i(data_strobe_n_o),
    .rw_i(rw_o), .addr_i(addr_o), .dly_i(dly), .width_i(pw), .data_o(data_i), .ack_hi_n_o(transfer_ack_size_hi_n_i),
    .ack_lo_n_o(transfer_ack_size_lo_n_i));
  // one bus cycle; request held up so callers may chain them
  task automatic op(input logic w, s, l, ia, input logic [31:0] a, d, output int n);
    {req_write_i, req_sync_i, req_lock_i, req_iack_i} = {w, s, l, ia};
    {req_addr_i, req_wdata_i, req_fc_i, req_size_i} = {a, d, a[2:0], a[4:3]};
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
      if (n > 60) begin fails++; results(); end
      if (address_strobe_n_o === 1'b0) begin
        `CHK("addr", {a, a[2:0], a[4:3], !w}, {addr_o, function_code_o, transfer_size_o, rw_o})
        if (l) `CHK("lock", 1'b0, locked_rmw_cycle_n_o)
      end
      if (data_strobe_n_o === 1'b0 && w) `CHK("wdata", {1'b1, d}, {data_oe_o, data_o})
      if (s && w) `CHK("ds", 1'b1, data_strobe_n_o)
    end while (req_done_o !== 1'b1 && req_bus_error_n_o !== 1'b1);
  endtask
  // drop the request and let one edge pass
  task automatic idle();
    req_valid_i = 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic t_rw();
    int n0, n1;
    op(0, 0, 0, 0, 32'h1234_5678, 32'h0, n0);
    `CHK("rdata", 32'h1234_5678 ^ 32'hA5A5_0F0F, req_rdata_o)
    `CHK("port", PORT_32, req_port_o)
    dly = 4'h5;
    op(0, 0, 0, 0, 32'h0000_00F0, 32'h0, n1);
    `CHK("ack wait", 5, n1 - n0)
    op(1, 0, 0, 0, 32'h0000_0104, 32'hCAFE_F00D, n0);
    op(1, 1, 0, 0, 32'h0000_0108, 32'h1357_9BDF, n0);
    `CHK("sync write", 3, n0)
    dly = 4'hF;
    op(0, 1, 0, 0, 32'h0000_010C, 32'h0, n0);
    `CHK("sync read", 3, n0)
    `CHK("sync rdata", 32'h0000_010C ^ 32'hA5A5_0F0F, req_rdata_o)
    idle();
  endtask
  task automatic t_lock();
    int n;
    dly = 4'h2;
    pw = PORT_16;
    op(0, 0, 1, 0, 32'h0000_0200, 32'h0, n);
    `CHK("lock gap", 1'b0, locked_rmw_cycle_n_o)
    `CHK("port 16", PORT_16, req_port_o)
    pw = PORT_8;
    op(1, 0, 1, 0, 32'h0000_0200, 32'h0000_00FF, n);
    `CHK("port 8", PORT_8, req_port_o)
    pw = PORT_32;
    req_lock_i = 1'b0;
    idle();
  endtask
  task automatic t_bus_error_n(input logic h);
    int n;
    dly = 4'hF;
    fork
      begin
        op(0, 0, 0, 0, 32'h0000_0300, 32'h0, n);
        `CHK("bus_error_n", {!h, h}, {req_bus_error_n_o, req_done_o})
        idle();
      end
      begin
        `WT(data_strobe_n_o === 1'b0, 20)
        {bus_error_n_i, ext_halt_n} = {1'b0, !h};
        repeat (5) @(negedge core_clk_i);
        if (h) `CHK("retry wait", 1'b1, address_strobe_n_o)
        bus_error_n_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        ext_halt_n = 1'b1;
      end
    join
  endtask
  task automatic t_halt();
    int n;
    dly = 4'h0;
    ext_halt_n = 1'b0;
    repeat (3) @(negedge core_clk_i);
    fork
      op(0, 0, 0, 0, 32'h0000_0500, 32'h0, n);
      begin
        repeat (8) begin
          @(negedge core_clk_i);
          `CHK("halted", 1'b1, address_strobe_n_o)
        end
        ext_halt_n = 1'b1;
      end
    join
    idle();
  endtask
  task automatic t_auto_vector_request_n();
    int n;
    auto_vector_request_n_i = 1'b0;
    dly = 4'hF;
    op(0, 0, 0, 1, 32'hFFFF_FFF8, 32'h0, n);
    `CHK("autovec", 2'h3, {req_done_o, req_autovec_o})
    auto_vector_request_n_i = 1'b1;
    idle();
  endtask
  task automatic t_irq();
    irq_mask_i = 3'h3;
    for (int l = 0; l < 8; l++) begin
      interrupt_level_n_i = ~3'(l);
      repeat (8) @(negedge core_clk_i);
      `CHK("pending", !(l > 3), interrupt_pending_out_n_o)
    end
    interrupt_level_n_i = 3'h7;
  endtask
  task automatic t_arb();
    bus_request_n_i = 1'b0;
    `WT(bus_grant_n_o === 1'b0, 10)
    grant_acknowledge_n_i = 1'b0;
    bus_request_n_i = 1'b1;
    `WT(bus_grant_n_o === 1'b1, 10)
    `CHK("bus off", 1'b0, bus_oe_o)
    grant_acknowledge_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic t_pins();
    cache_disable_n_i = 1'b0;
    double_fault_i = 1'b1;
    `WT(halt_oe_o === 1'b1, 10)
    `CHK("halt pull", 1'b0, halt_n_o)
    repeat (3) @(negedge core_clk_i);
    `CHK("cache off", 1'b0, cache_enable_o)
    {cache_disable_n_i, double_fault_i} = 2'h2;
    repeat (5) @(negedge core_clk_i);
    `CHK("cache on", 2'h2, {cache_enable_o, halt_oe_o})
  endtask
  task automatic t_rst();
    int c = 0;
    reset_instr_i = 1'b1;
    @(negedge core_clk_i);
    reset_instr_i = 1'b0;
    `WT(reset_oe_o === 1'b1, 5)
    while (reset_oe_o === 1'b1 && c < 40) begin
      `CHK("own reset", 2'h0, {core_reset_o, reset_n_o})
      c++;
      @(negedge core_clk_i);
    end
    `CHK("drive len", RC, c)
    repeat (5) @(negedge core_clk_i);
    ext_rst_n = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK("ext reset", 1'b1, core_reset_o)
    ext_rst_n = 1'b1;
    repeat (6) @(negedge core_clk_i);
  endtask
  // verdict and end of run
  task automatic results();
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(negedge core_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    t_rw();
    t_lock();
    t_bus_error_n(1'b0);
    t_bus_error_n(1'b1);
    t_halt();
    t_auto_vector_request_n();
    t_irq();
    t_arb();
    t_pins();
    t_rst();
    results();
  end
endmodule // tb
